/* File: core/asc_pkg.sv */
// Constants, register map and carrier types of the conversion sequencer.
// Assumes one system clock; the analog core answers on that same clock.
package asc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int          RES_W    = 12;
  localparam int          RAW_W    = 13;
  localparam int          CH_W     = 4;
  localparam int          NSLOT    = 16;
  localparam int          PS_W     = 4;
  localparam int          ADR_W    = 5;
  localparam logic [11:0] CODE_MAX = 12'hFFF;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL  = 5'h00;
  localparam logic [4:0] REG_PRESC = 5'h01;
  localparam logic [4:0] REG_STAT  = 5'h02;
  localparam logic [4:0] REG_CH_LO = 5'h03;
  localparam logic [4:0] REG_CH_HI = 5'h04;
  localparam int         RES_BIT   = 4;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTL_CASCADE = 0;
  localparam int CTL_ALT_IRQ = 1;
  localparam int CTL_STST    = 2;
  localparam int CTL_SW_A    = 3;
  localparam int CTL_SW_B    = 4;
  localparam int CTL_PWM_A   = 5;
  localparam int CTL_PWM_B   = 6;
  localparam int CTL_EXT_A   = 7;
  localparam int CTL_LAST_A  = 8;
  localparam int CTL_LAST_B  = 12;
  localparam int PS_ACQ      = 0;
  localparam int PS_CLK      = 4;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [4:0]       addr;
    logic [31:0]      wdata;
  } asc_bus_req_t;

  typedef struct packed {
    logic             done;
    logic             under;
    logic [12:0]      raw;
  } asc_core_res_t;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_ACQ  = 3'b010,
    ENG_CONV = 3'b100
  } asc_eng_t;

  typedef struct packed {
    asc_eng_t         eng;
    logic             cascade;
    logic             alt_irq;
    logic             stst;
    logic             pwm_a;
    logic             pwm_b;
    logic             ext_a;
    logic [3:0]       last_a;
    logic [2:0]       last_b;
    logic [3:0]       acq_ps;
    logic [3:0]       clk_ps;
    logic [15:0][3:0] chsel;
    logic [15:0][11:0] res;
    logic [3:0]       ptr_a;
    logic [2:0]       ptr_b;
    logic             req_a;
    logic             req_b;
    logic             act_a;
    logic             act_b;
    logic             par_a;
    logic             par_b;
    logic             cur_b;
    logic [3:0]       slot;
    logic [3:0]       div;
    logic [3:0]       cnt;
    logic             ext_s1;
    logic             ext_s2;
    logic             ext_d;
    logic [31:0]      rdata;
    logic             analog_on;
    logic             sh;
    logic             start;
    logic [3:0]       chan;
    logic             irq_a;
    logic             irq_b;
  } asc_state_t;

endpackage

/* File: core/asc_sequencer.sv */
// Conversion sequencer around one shared 12-bit sample-and-hold converter.
// Assumes triggers and core answers on clk_sys; the interrupt-two pin is async.
//
// What this block does
// RULE1: Results are 12-bit codes from one converter with built-in sample-and-hold.
// RULE2: Code clamps to 0 below zero and 4095 at full scale, truncated between.
// RULE3: Up to sixteen conversions per session, each slot picks any input.
// RULE4: Two independent eight-state sequencers or one cascaded sixteen-state sequencer.
// RULE5: Sixteen individually addressable result registers.
// RULE6: Each finished conversion lands in the result register of its slot.
// RULE7: Both sequencers share one converter; conversions are serialized.
// RULE8: Starts come from software, pwm_modules triggers or the interrupt-two pin.
// RULE9: In dual mode triggers A and B start their sequencers independently.
// RULE10: Interrupt request on every end of sequence or every second one.
// RULE11: Start/stop mode advances one slot per trigger.
// RULE12: Acquisition window has its own prescaler, apart from conversion clock.
// RULE13: Registers on system clock; conversion timing from fast peripheral tick.
// RULE14: Clock enable low after reset; reset still initialises all registers.
// RULE15: After reset, register logic stays frozen until clock enable goes high.
// RULE16: Clock enable high runs registers and powers the analog section.
// RULE17: Software waits a settling delay after enabling before any conversion.
// RULE18: Halt puts analog in low power and keeps register contents.
// RULE19: Halt stops the register logic.
// RULE20: Steps slots in order, flags end of sequence, returns to slot zero.
`timescale 1ns/1ns
module asc_sequencer
(
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  input  wire logic                     conv_clock_enable,
  input  wire logic                     halt,
  input  wire asc_pkg::asc_bus_req_t    bus_req,
  output logic [31:0]                   rdata,
  input  wire logic                     trigger_seq_a,
  input  wire logic                     trigger_seq_b,
  input  wire logic                     ext_irq_two_trigger,
  input  wire asc_pkg::asc_core_res_t   core_res,
  output logic                          analog_on,
  output logic                          sample_hold,
  output logic                          conv_start,
  output logic [3:0]                    chan_sel,
  output logic                          irq_seq_a,
  output logic                          irq_seq_b
);

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  asc_pkg::asc_state_t s_r;
  asc_pkg::asc_state_t s_nxt;
  logic                run;
  logic                tick;
  logic                ext_rise;
  logic                sw_a;
  logic                sw_b;
  logic                trig_a;
  logic                trig_b;
  logic                go_a;
  logic                go_b;
  logic [3:0]          last_a_eff;
  logic [11:0]         code;
  logic                wr_ctrl;

  assign run        = conv_clock_enable & ~halt;                   // [RULE15] [RULE16] [RULE19]
  assign tick       = s_r.div == s_r.clk_ps;                       // [RULE13]
  assign ext_rise   = s_r.ext_s2 & ~s_r.ext_d;
  assign wr_ctrl    = bus_req.wr && bus_req.addr == asc_pkg::REG_CTRL;
  assign sw_a       = wr_ctrl & bus_req.wdata[asc_pkg::CTL_SW_A];
  assign sw_b       = wr_ctrl & bus_req.wdata[asc_pkg::CTL_SW_B];
  // Sources of each start; B is silent when cascaded
  assign trig_a     = sw_a | (s_r.pwm_a & trigger_seq_a)
                    | (s_r.ext_a & ext_rise);                      // [RULE8]
  assign trig_b     = ~s_r.cascade & (sw_b | (s_r.pwm_b & trigger_seq_b)); // [RULE9]
  assign go_a       = s_r.req_a | s_r.act_a;
  assign go_b       = ~s_r.cascade & (s_r.req_b | s_r.act_b);
  assign last_a_eff = s_r.cascade ? s_r.last_a
                                  : {1'b0, s_r.last_a[2:0]};      // [RULE4]
  // Clamp to the code range
  assign code       = core_res.under ? '0
                    : (core_res.raw > {1'b0, asc_pkg::CODE_MAX}) ? asc_pkg::CODE_MAX
                    : core_res.raw[11:0];                          // [RULE1] [RULE2]

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    if (!run)
    begin
      // Frozen, analog section off
      s_nxt.analog_on = 1'b0;                                      // [RULE14] [RULE18]
    end
    else
    begin
      s_nxt.analog_on = 1'b1;                                      // [RULE16]
      s_nxt.start     = 1'b0;
      s_nxt.irq_a     = 1'b0;
      s_nxt.irq_b     = 1'b0;
      s_nxt.rdata     = '0;
      s_nxt.ext_s1    = ext_irq_two_trigger;
      s_nxt.ext_s2    = s_r.ext_s1;
      s_nxt.ext_d     = s_r.ext_s2;
      s_nxt.div       = tick ? '0 : s_r.div + 4'h1;

      // Register writes
      if (bus_req.wr)
      begin
        if (bus_req.addr == asc_pkg::REG_CTRL)
        begin
          s_nxt.cascade = bus_req.wdata[asc_pkg::CTL_CASCADE];
          s_nxt.alt_irq = bus_req.wdata[asc_pkg::CTL_ALT_IRQ];
          s_nxt.stst    = bus_req.wdata[asc_pkg::CTL_STST];
          s_nxt.pwm_a   = bus_req.wdata[asc_pkg::CTL_PWM_A];
          s_nxt.pwm_b   = bus_req.wdata[asc_pkg::CTL_PWM_B];
          s_nxt.ext_a   = bus_req.wdata[asc_pkg::CTL_EXT_A];
          s_nxt.last_a  = bus_req.wdata[asc_pkg::CTL_LAST_A +: 4];
          s_nxt.last_b  = bus_req.wdata[asc_pkg::CTL_LAST_B +: 3];
        end
        else if (bus_req.addr == asc_pkg::REG_PRESC)
        begin
          s_nxt.acq_ps  = bus_req.wdata[asc_pkg::PS_ACQ +: asc_pkg::PS_W]; // [RULE12]
          s_nxt.clk_ps  = bus_req.wdata[asc_pkg::PS_CLK +: asc_pkg::PS_W];
        end
        else if (bus_req.addr == asc_pkg::REG_CH_LO)
        begin
          s_nxt.chsel[7:0]  = bus_req.wdata;                       // [RULE3]
        end
        else if (bus_req.addr == asc_pkg::REG_CH_HI)
        begin
          s_nxt.chsel[15:8] = bus_req.wdata;
        end
      end

      // Register reads, data in the next cycle
      if (bus_req.rd)
      begin
        if (bus_req.addr[asc_pkg::RES_BIT])
        begin
          s_nxt.rdata = {20'h0, s_r.res[bus_req.addr[3:0]]};      // [RULE5]
        end
        else
        begin
          unique case (bus_req.addr)
            asc_pkg::REG_CTRL:
              s_nxt.rdata = {17'h0, s_r.last_b, s_r.last_a, s_r.ext_a, s_r.pwm_b,
                             s_r.pwm_a, 2'b00, s_r.stst, s_r.alt_irq, s_r.cascade};
            asc_pkg::REG_PRESC:
              s_nxt.rdata = {24'h0, s_r.clk_ps, s_r.acq_ps};
            asc_pkg::REG_STAT:
              s_nxt.rdata = {20'h0, s_r.ptr_b, s_r.ptr_a, s_r.act_b, s_r.act_a,
                             s_r.req_b, s_r.req_a, s_r.eng != asc_pkg::ENG_IDLE};
            asc_pkg::REG_CH_LO:
              s_nxt.rdata = s_r.chsel[7:0];
            asc_pkg::REG_CH_HI:
              s_nxt.rdata = s_r.chsel[15:8];
            default:
              s_nxt.rdata = '0;
          endcase
        end
      end

      // ------------------------------------------------------------
      // Conversion engine, one converter for both sequencers
      // ------------------------------------------------------------
      unique case (s_r.eng)
        asc_pkg::ENG_IDLE:
        begin
          // A first, B only when A is idle
          if (go_a)                                                // [RULE7]
          begin
            s_nxt.cur_b = 1'b0;
            s_nxt.slot  = s_r.ptr_a;
            s_nxt.req_a = 1'b0;
            s_nxt.act_a = ~s_r.stst;                               // [RULE11]
          end
          else if (go_b)
          begin
            s_nxt.cur_b = 1'b1;
            s_nxt.slot  = {1'b1, s_r.ptr_b};
            s_nxt.req_b = 1'b0;
            s_nxt.act_b = ~s_r.stst;                               // [RULE11]
          end
          if (go_a | go_b)
          begin
            s_nxt.eng  = asc_pkg::ENG_ACQ;
            s_nxt.cnt  = '0;
            s_nxt.div  = '0;
            s_nxt.sh   = 1'b1;
            s_nxt.chan = s_r.chsel[go_a ? s_r.ptr_a : {1'b1, s_r.ptr_b}]; // [RULE3]
          end
        end
        asc_pkg::ENG_ACQ:
        begin
          // Window lasts acq_ps+1 ticks
          if (tick)
          begin
            if (s_r.cnt == s_r.acq_ps)                             // [RULE12]
            begin
              s_nxt.sh    = 1'b0;
              s_nxt.start = 1'b1;
              s_nxt.eng   = asc_pkg::ENG_CONV;
            end
            else
            begin
              s_nxt.cnt = s_r.cnt + 4'h1;
            end
          end
        end
        asc_pkg::ENG_CONV:
        begin
          if (core_res.done)
          begin
            s_nxt.res[s_r.slot] = code;                            // [RULE6]
            s_nxt.eng           = asc_pkg::ENG_IDLE;
            if (!s_r.cur_b)
            begin
              if (s_r.ptr_a >= last_a_eff)                         // [RULE20]
              begin
                s_nxt.ptr_a = '0;
                s_nxt.act_a = 1'b0;
                s_nxt.irq_a = ~s_r.alt_irq | s_r.par_a;            // [RULE10]
                s_nxt.par_a = ~s_r.par_a;
              end
              else
              begin
                s_nxt.ptr_a = s_r.ptr_a + 4'h1;
              end
            end
            else
            begin
              if (s_r.ptr_b >= s_r.last_b)                         // [RULE20]
              begin
                s_nxt.ptr_b = '0;
                s_nxt.act_b = 1'b0;
                s_nxt.irq_b = ~s_r.alt_irq | s_r.par_b;            // [RULE10]
                s_nxt.par_b = ~s_r.par_b;
              end
              else
              begin
                s_nxt.ptr_b = s_r.ptr_b + 3'h1;
              end
            end
          end
        end
        default:
          s_nxt.eng = asc_pkg::ENG_IDLE;
      endcase

      // Trigger set wins over the grant's clear
      s_nxt.req_a = s_nxt.req_a | trig_a;                          // [RULE8]
      s_nxt.req_b = s_nxt.req_b | trig_b;                          // [RULE9]
    end
  end

  // ----------------------------------------------------------------
  // State register; reset acts whatever the clock enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      s_r     <= '0;                                               // [RULE14]
      s_r.eng <= asc_pkg::ENG_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rdata       = s_r.rdata;
  assign analog_on   = s_r.analog_on;
  assign sample_hold = s_r.sh;
  assign conv_start  = s_r.start;
  assign chan_sel    = s_r.chan;
  assign irq_seq_a   = s_r.irq_a;
  assign irq_seq_b   = s_r.irq_b;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_power_follow: assert property (run |=> analog_on) // [RULE16]
    else $error("analog section not powered while enabled");
  chk_halt_power: assert property (!run |=> !analog_on) // [RULE18]
    else $error("analog section powered while halted or disabled");
  chk_freeze_regs: assert property (!run |=> $stable(s_r.res) && $stable(s_r.ptr_a)
                                             && $stable(s_r.eng)) // [RULE19]
    else $error("state moved while frozen");
  chk_code_clamp: assert property ((run && s_r.eng == asc_pkg::ENG_CONV && core_res.done
                                    && !core_res.under && core_res.raw[12])
                                   |=> s_r.res[$past(s_r.slot)] == asc_pkg::CODE_MAX) // [RULE2]
    else $error("over-range code not clamped");
  chk_acq_window: assert property (conv_start |-> $past(s_r.cnt) == $past(s_r.acq_ps)
                                   && s_r.eng == asc_pkg::ENG_CONV) // [RULE12]
    else $error("conversion started before window end");
  chk_one_engine: assert property ($onehot(s_r.eng) && (!sample_hold
                                   || s_r.eng == asc_pkg::ENG_ACQ)) // [RULE7]
    else $error("engine state not single");
  chk_chan_pick: assert property ($rose(sample_hold) |-> chan_sel == s_r.chsel[s_r.slot]) // [RULE3]
    else $error("wrong channel for slot");
  chk_eos_wrap: assert property ((run && s_r.eng == asc_pkg::ENG_CONV && core_res.done
                                  && !s_r.cur_b && s_r.ptr_a >= last_a_eff && !s_r.alt_irq)
                                 |=> irq_seq_a && s_r.ptr_a == '0 ##1 !irq_seq_a) // [RULE20]
    else $error("end of sequence not flagged");
  chk_trig_latch: assert property ((run && s_r.pwm_a && trigger_seq_a) |=> s_r.req_a) // [RULE8]
    else $error("trigger lost");
  chk_cascade_b: assert property (s_r.cascade && s_r.eng == asc_pkg::ENG_IDLE
                                  |=> !s_r.cur_b || s_r.eng == asc_pkg::ENG_IDLE) // [RULE4]
    else $error("sequencer B ran while cascaded");
  chk_stst_step: assert property ((run && s_r.stst && s_r.eng == asc_pkg::ENG_IDLE && go_a)
                                  |=> !s_r.act_a) // [RULE11]
    else $error("start/stop ran past one slot");

  cov_eos_a: cover property (irq_seq_a);
  cov_eos_b: cover property (irq_seq_b);
  cov_alt_skip: cover property (s_r.alt_irq && $changed(s_r.par_a) && !irq_seq_a);
  cov_cascade_top: cover property (s_r.cascade && s_r.slot == 4'hF && core_res.done);

endmodule // asc_sequencer

/* File: testbench/asc_core_model.sv */
// Behavioural model of the analog converter core and its input multiplexer.
// Assumes the sequencer drives sample_hold, conv_start and chan_sel on clk_sys.
`timescale 1ns/1ns
module asc_core_model
(
  input  wire logic              clk_sys,
  input  wire logic              analog_on,
  input  wire logic              sample_hold,
  input  wire logic              conv_start,
  input  wire logic [3:0]        chan_sel,
  input  wire logic              slow,
  output asc_pkg::asc_core_res_t core_res
);
  int         busy_cnt = 0;
  logic [3:0] held_ch  = 4'h0;

  initial core_res = '0;

  // ----------------------------------------------------------------
  // One converter, input tracked during the acquisition window and held after it
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    core_res.done <= 1'b0;
    if (sample_hold && analog_on)
      held_ch <= chan_sel;
    if (conv_start && analog_on && busy_cnt == 0)
      busy_cnt <= slow ? 9 : 2;
    else if (busy_cnt > 1)
      busy_cnt <= busy_cnt - 1;
    else if (busy_cnt == 1)
    begin
      busy_cnt       <= 0;
      core_res.done  <= 1'b1;
      core_res.under <= (held_ch == 4'h0);
      core_res.raw   <= 13'(held_ch) * 13'h111 + 13'h5;
    end
    else
    begin
      // Lines not valid outside done: keep them moving
      core_res.under <= ~core_res.under;
      core_res.raw   <= ~core_res.raw;
    end
  end
endmodule // asc_core_model

/* File: testbench/asc_sequencer_bench.sv */
// Self-checking bench of the conversion sequencer against a queue model.
// Assumes asc_core_model answers conversions; one clock at 25 MHz.
`timescale 1ns/1ns
module asc_sequencer_bench;
  localparam int SA = 1 << asc_pkg::CTL_SW_A;
  localparam int SB = 1 << asc_pkg::CTL_SW_B;
  logic                   clk_sys = 1'b0;
  logic                   rstn = 1'b0;
  logic                   conv_clock_enable = 1'b0;
  logic                   halt = 1'b0;
  asc_pkg::asc_bus_req_t  bus_req = '0;
  logic                   trigger_seq_a = 1'b0;
  logic                   trigger_seq_b = 1'b0;
  logic                   ext_irq_two_trigger = 1'b0;
  logic                   slow = 1'b0;
  asc_pkg::asc_core_res_t core_res;
  logic [31:0]            rdata;
  logic                   analog_on;
  logic                   sample_hold;
  logic                   conv_start;
  logic [3:0]             chan_sel;
  logic                   irq_seq_a;
  logic                   irq_seq_b;
  int                     err_count = 0;
  int                     check_count = 0;
  int                     seed = 32'hb1d3;
  int                     n_conv = 0;
  int                     sh_len = 0;
  int                     win = 1;
  int                     ia = 0;
  int                     ib = 0;
  int                     n0;
  int                     chs[16];
  logic [3:0]             seen_ch[$];
  logic [31:0]            rd_val;
  logic [31:0]            ctl_w;

  asc_sequencer asc_sequencer_i (.clk_sys(clk_sys), .rstn(rstn), .conv_clock_enable(conv_clock_enable),
    .halt(halt), .bus_req(bus_req), .rdata(rdata), .trigger_seq_a(trigger_seq_a),
    .trigger_seq_b(trigger_seq_b), .ext_irq_two_trigger(ext_irq_two_trigger), .core_res(core_res),
    .analog_on(analog_on), .sample_hold(sample_hold), .conv_start(conv_start), .chan_sel(chan_sel),
    .irq_seq_a(irq_seq_a), .irq_seq_b(irq_seq_b));
  asc_core_model asc_core_model_i (.clk_sys(clk_sys), .analog_on(analog_on), .sample_hold(sample_hold),
    .conv_start(conv_start), .chan_sel(chan_sel), .slow(slow), .core_res(core_res));

  always #20 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t %s: saw %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic int code(input int ch);
    if (ch == 0)
      return 0;
    return (ch * 273 + 5 > 4095) ? 4095 : ch * 273 + 5;
  endfunction

  function automatic logic [31:0] ctl(input int m, input int la, input int lb);
    return 32'(m) | (32'(la) << asc_pkg::CTL_LAST_A) | (32'(lb) << asc_pkg::CTL_LAST_B);
  endfunction

  task automatic prog_rand();
    logic [63:0] cw;
    int          acq;
    int          ck;
    for (int i = 0; i < 16; i++)
      chs[i] = $unsigned($random(seed)) % 16;
    chs[1] = chs[0]; // Same input twice
    chs[2]  = 0;  // Input below zero
    chs[15] = 15; // Input over full scale
    for (int i = 0; i < 16; i++)
      cw[4*i +: 4] = 4'(chs[i]);
    acq = $unsigned($random(seed)) % 4;
    ck  = $unsigned($random(seed)) % 4;
    win = (acq + 1) * (ck + 1);
    wr_reg(asc_pkg::REG_CH_LO, cw[31:0]);
    wr_reg(asc_pkg::REG_CH_HI, cw[63:32]);
    wr_reg(asc_pkg::REG_PRESC, 32'(acq) | (32'(ck) << asc_pkg::PS_CLK));
    seen_ch.delete();
  endtask

  task automatic wait_conv(input int n);
    repeat (3000)
      if (n_conv < n)
        @(posedge clk_sys);
    if (n_conv < n)
    begin
      err_count++;
      $display("BAD %0t conversion wait ran out", $time);
      wrap_up();
    end
    repeat (16) @(posedge clk_sys);
  endtask

  task automatic chk_slots(input int first, input int last);
    for (int s = first; s <= last; s++)
    begin
      chk(32'(seen_ch.pop_front()), 32'(chs[s]), "slot channel");
      rd_reg(5'(16 + s), rd_val);
      chk(rd_val, 32'(code(chs[s])), "result");
    end
  endtask

  task automatic pulse(input int b);
    @(posedge clk_sys);
    if (b == 0) trigger_seq_a <= 1'b1;
    else trigger_seq_b <= 1'b1;
    @(posedge clk_sys);
    trigger_seq_a <= 1'b0;
    trigger_seq_b <= 1'b0;
  endtask

  // Window length and channel of every conversion
  always @(posedge clk_sys)
  begin
    if (irq_seq_a === 1'b1) ia++;
    if (irq_seq_b === 1'b1) ib++;
    if (sample_hold === 1'b1)
    begin
      if (sh_len == 0) seen_ch.push_back(chan_sel);
      sh_len++;
    end
    else if (sh_len != 0)
    begin
      chk(32'(sh_len), 32'(win), "window");
      n_conv++;
      sh_len = 0;
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    chk(analog_on, 1'b0, "analog after reset");
    wr_reg(asc_pkg::REG_CTRL, ctl(SA, 5, 2));
    rd_reg(asc_pkg::REG_CTRL, rd_val);
    chk(rd_val, 32'h0, "frozen read");
    repeat (10) @(posedge clk_sys);
    chk(32'(n_conv), 32'h0, "frozen start");
    conv_clock_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk(analog_on, 1'b1, "analog enabled");
    repeat (25000) @(posedge clk_sys); // Settling time before any start
    rd_reg(asc_pkg::REG_CTRL, rd_val);
    chk(rd_val, 32'h0, "ctrl default");
    rd_reg(5'h05, rd_val);
    chk(rd_val, 32'h0, "unmapped read");
    $display("test reset done");

    prog_rand();
    n0 = n_conv;
    wr_reg(asc_pkg::REG_CTRL, ctl(SA | SB, 3, 2));
    wait_conv(n0 + 7);
    chk(32'(n_conv - n0), 32'h7, "dual count");
    chk(32'(ia), 32'h1, "dual irq a");
    chk(32'(ib), 32'h1, "dual irq b");
    chk_slots(0, 3);
    chk_slots(8, 10);
    $display("test dual done");

    prog_rand();
    slow <= 1'b1;
    ia = 0;
    n0 = n_conv;
    ctl_w = ctl((1 << asc_pkg::CTL_CASCADE) | (1 << asc_pkg::CTL_ALT_IRQ) | (1 << asc_pkg::CTL_PWM_A)
      | (1 << asc_pkg::CTL_PWM_B), 15, 0);
    wr_reg(asc_pkg::REG_CTRL, ctl_w);
    pulse(0);
    pulse(1);
    wait_conv(n0 + 16);
    chk(32'(ia), 32'h1, "second end since reset fires");
    chk_slots(0, 15);
    pulse(0);
    wait_conv(n0 + 32);
    chk(32'(n_conv - n0), 32'd32, "cascade count, b ignored");
    chk(32'(ia), 32'h1, "third end skipped");
    $display("test cascade done");

    prog_rand();
    slow <= 1'b0;
    ia = 0;
    n0 = n_conv;
    ctl_w = ctl((1 << asc_pkg::CTL_STST) | (1 << asc_pkg::CTL_EXT_A), 2, 0);
    wr_reg(asc_pkg::REG_CTRL, ctl_w);
    for (int k = 1; k <= 3; k++)
    begin
      @(posedge clk_sys) ext_irq_two_trigger <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_irq_two_trigger <= 1'b0;
      wait_conv(n0 + k);
      chk(32'(n_conv - n0), 32'(k), "one slot per trigger");
      chk(32'(ia), 32'(k / 3), "end after last slot");
    end
    chk_slots(0, 2);
    $display("test start stop done");

    halt <= 1'b1;
    n0 = n_conv;
    wr_reg(asc_pkg::REG_CTRL, ctl(SA, 5, 5));
    pulse(0);
    #1 chk(analog_on, 1'b0, "analog off in halt");
    repeat (10) @(posedge clk_sys);
    chk(32'(n_conv - n0), 32'h0, "halted start");
    halt <= 1'b0;
    rd_reg(asc_pkg::REG_CTRL, rd_val);
    chk(rd_val, ctl_w, "ctrl kept");
    rd_reg(5'h10, rd_val);
    chk(rd_val, 32'(code(chs[0])), "result kept");
    $display("test halt done");

    ib = 0;
    ia = 0;
    wr_reg(asc_pkg::REG_CTRL, ctl((1 << asc_pkg::CTL_PWM_A) | (1 << asc_pkg::CTL_PWM_B), 3, 2));
    pulse(1);
    wait_conv(n0 + 3);
    chk(32'(n_conv - n0), 32'h3, "b alone count");
    chk(32'(ib * 2 + ia), 32'h2, "b alone irq");
    $display("test pwm b done");
    wrap_up();
  end
endmodule // asc_sequencer_bench
